/* verilog/srsm_pkg.sv */
// Shared constants, register map and state type of the reset and supply monitor.
`default_nettype none
package srsm_pkg;
  localparam int CLK_MHZ = 100;
  // Reset pulse lengths, least values in microseconds.
  localparam int T_RST_COLD0_US = 20000;
  localparam int T_RST_COLD1_US = 10000;
  localparam int T_RST_COLD2_US = 3600;
  localparam int T_RST_WARM_US = 1000;
  localparam logic [23:0] C_RST_COLD0_CYC = 24'(T_RST_COLD0_US * CLK_MHZ);
  localparam logic [23:0] C_RST_COLD1_CYC = 24'(T_RST_COLD1_US * CLK_MHZ);
  localparam logic [23:0] C_RST_COLD2_CYC = 24'(T_RST_COLD2_US * CLK_MHZ);
  localparam logic [23:0] C_RST_WARM_CYC = 24'(T_RST_WARM_US * CLK_MHZ);
  localparam logic [23:0] C_STARTUP_CYC = 24'h0003E8;
  localparam logic [23:0] C_RST_IN_MIN_CYC = 24'h000004;
  localparam logic [2:0] C_SENSE_GUARD = 3'h4;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_SUPPLY_CTRL = 8'h10;
  localparam logic [7:0] IDX_SUPPLY_STAT = 8'h1B;
  localparam logic [7:0] IDX_STARTUP_CTRL = 8'h73;
  localparam logic [7:0] IDX_CONFIG_CTRL = 8'h74;
  localparam logic [7:0] IDX_EVENT_STAT = 8'h80;
  localparam logic [7:0] IDX_EVENT_ENA = 8'h81;
  // Field positions.
  localparam int F_THR_LSB = 0;
  localparam int F_AUXCFG_LSB = 2;
  localparam int F_BELOW = 0;
  localparam int F_SSTAT_LSB = 1;
  localparam int F_PLEN_LSB = 4;
  localparam int F_AUXSU = 3;
  localparam int F_THRSU_LSB = 4;
  localparam int F_EV_WARN = 0;
  localparam int F_EV_OTW = 1;
  localparam int F_EV_PO = 2;
  localparam int F_OVERTEMP_WARN_STATUS = 1;
  // Reset values; factory presets for the start-up fields.
  localparam logic [1:0] RST_PLEN = 2'h0;
  localparam logic RST_AUXSU = 1'b0;
  localparam logic [1:0] RST_THRSU = 2'h0;
  localparam logic [1:0] RST_THR = 2'h0;
  localparam logic [1:0] RST_AUXCFG = 2'h0;
  localparam logic RST_WARN_ENA = 1'b0;
  // Operating modes reported by the mode controller.
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_STANDBY = 2'h1;
  localparam logic [1:0] OPM_SLEEP = 2'h2;
  // Sensor supply status codes.
  localparam logic [1:0] SST_OK = 2'h0;
  localparam logic [1:0] SST_UV = 2'h1;
  localparam logic [1:0] SST_OV = 2'h2;
  localparam logic [1:0] SST_OFF = 2'h3;
  // Synchronised pin vector positions.
  localparam int P_RSTPIN = 0;
  localparam int P_BELOW0 = 1;
  localparam int P_TACT = 5;
  localparam int P_TREL = 6;
  localparam int P_TWARN = 7;
  localparam int P_POFF = 8;
  localparam int P_PON = 9;
  localparam int P_SUV = 10;
  localparam int P_SOV = 11;
  localparam int NPINS = 12;
  typedef enum logic [2:0] {
    SRSM_OFF, SRSM_STARTUP, SRSM_RESET, SRSM_OVERTEMP, SRSM_RUN
  } srsm_state_t;
endpackage : srsm_pkg
`default_nettype wire

/* verilog/srsm_top.sv */
// Reset generation, reset sources and supply supervision with APB registers.
// What this block does
// (RL1) Any system reset enters Reset, drives pin low.
// (RL2) Open-drain pin; external low sensed, minimum width.
// (RL3) Undervoltage-linked resets are cold, length per field.
// (RL4) Other resets except Sleep wake-up and Overtemp exit are warm, shortest pulse length.
// (RL5) Pulse field selects four cold pulse lengths.
// (RL6) Start-up bit loads output config 00 or 11.
// (RL7) Undervoltage, external pin, watchdog faults cause reset.
// (RL8) Watchdog write, mode exits, wakes, illegal sleep reset.
// (RL9) Overtemp outside Sleep/Off/Start-up: reset low, supplies off.
// (RL10) Cooling leaves Overtemp via Reset into Standby.
// (RL11) Warning threshold sets status and captures event.
// (RL12) Battery below power-off threshold enters Off.
// (RL13) Power-on: wait start-up, enter Reset, flag event.
// (RL14) Threshold field picks 90/80/70/60 percent reset level.
// (RL15) Threshold field loads from start-up setting.
// (RL16) Below 90 percent raises warning when enabled.
// (RL17) Status bit shows main supply below 90 percent.
// (RL18) Output config field selects modes with output on.
// (RL19) Sensor status reports ok/uv/ov/disabled, else 00.
// (RL20) Start-up threshold field, same encoding, preset 00.
// (RL21) Release pin after pulse when sources are gone.
`timescale 1ns/1ps
`default_nettype none
module srsm_top
  import srsm_pkg::*;
#(
  parameter logic [23:0] COLD0_CYC = C_RST_COLD0_CYC,
  parameter logic [23:0] COLD1_CYC = C_RST_COLD1_CYC,
  parameter logic [23:0] COLD2_CYC = C_RST_COLD2_CYC,
  parameter logic [23:0] WARM_CYC = C_RST_WARM_CYC,
  parameter logic [23:0] STARTUP_CYC = C_STARTUP_CYC,
  parameter logic [23:0] RST_IN_MIN_CYC = C_RST_IN_MIN_CYC,
  parameter bit HAS_SENSOR = 1'b1
) (
  // Clock, reset and enable.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Reset pin, open drain.
  input wire logic bidir_reset_pin_in,
  output logic bidir_reset_pin_out,
  output logic bidir_reset_pin_oe_n_out,
  // Analog comparators, asynchronous.
  input wire logic [3:0] main_supply_below_in,
  input wire logic temp_above_act_in,
  input wire logic temp_above_rel_in,
  input wire logic temp_above_warn_in,
  input wire logic bat_below_poff_in,
  input wire logic bat_above_pon_in,
  input wire logic sensor_uv_in,
  input wire logic sensor_ov_in,
  // Same-clock events from watchdog, wake and mode logic.
  input wire logic [1:0] op_mode_in,
  input wire logic wd_overflow_window_in,
  input wire logic wd_early_trigger_in,
  input wire logic wd_overflow_timeout_in,
  input wire logic watchdog_failure_pending_in,
  input wire logic wd_ctrl_write_in,
  input wire logic sleep_wake_in,
  input wire logic illegal_sleep_cmd_in,
  // Mode and supply outputs.
  output logic reset_mode_out,
  output logic overtemp_mode_out,
  output logic off_mode_out,
  output logic enter_standby_out,
  output logic main_supply_en_out,
  output logic can_enable_out,
  output logic aux_output_en_out
);
  srsm_state_t state_reg, state_next;
  logic [NPINS-1:0] pins, sync1_reg, sync2_reg, prev_reg;
  logic [23:0] cnt_reg, cnt_next, ext_cnt_reg, ext_cnt_next, plen;
  logic [2:0] guard_reg, guard_next;
  logic cold_reg, cold_next, stby_reg, stby_next, drive_reg, drive_next;
  logic aux_reg, aux_next, load_ctl, ext_rst, uv_sel, warm_src, sleep_mode;
  logic temp_mon;
  logic [1:0] thr_reg, thr_next, auxcfg_reg, auxcfg_next;
  logic [1:0] plen_reg, plen_next, thrsu_reg, thrsu_next;
  logic auxsu_reg, auxsu_next, warn_ena_reg, warn_ena_next;
  logic [2:0] ev_reg, ev_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next, hit, wr_acc;
  logic [1:0] sstat;
  logic [7:0] idx;

  assign pins = {sensor_ov_in, sensor_uv_in, bat_above_pon_in,
                 bat_below_poff_in, temp_above_warn_in, temp_above_rel_in,
                 temp_above_act_in, main_supply_below_in, bidir_reset_pin_in};

  // Two-stage synchronisers; the second stage and its one-cycle delayed copy feed logic.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else if (ce_in) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign sleep_mode = (state_reg == SRSM_RUN) && (op_mode_in == OPM_SLEEP);
  assign uv_sel = sync2_reg[P_BELOW0 + int'(thr_reg)]; // RL14
  assign temp_mon = (state_reg != SRSM_OFF) && !sleep_mode; // RL9
  assign ext_rst = (ext_cnt_reg >= RST_IN_MIN_CYC); // RL2
  // Warm sources; a wake-up out of Sleep is counted as cold below.
  assign warm_src = ext_rst | wd_overflow_window_in | wd_early_trigger_in
    | (wd_overflow_timeout_in & watchdog_failure_pending_in) // RL7
    | (wd_ctrl_write_in && state_reg == SRSM_RUN
       && op_mode_in == OPM_NORMAL) // RL8
    | illegal_sleep_cmd_in; // RL8

  always_comb begin
    case (plen_reg) // RL5
      2'h0: plen = COLD0_CYC;
      2'h1: plen = COLD1_CYC;
      2'h2: plen = COLD2_CYC;
      default: plen = WARM_CYC;
    endcase
    if (!cold_reg) begin
      plen = WARM_CYC; // RL4
    end
  end

  // Mode sequencer.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cold_next = cold_reg;
    stby_next = 1'b0;
    drive_next = drive_reg;
    load_ctl = 1'b0;
    guard_next = (guard_reg != 3'h0) ? guard_reg - 3'h1 : 3'h0;
    ext_cnt_next = ext_cnt_reg;
    // The pin is sensed only after our own drive has settled away.
    if (drive_reg || guard_reg != 3'h0 || sync2_reg[P_RSTPIN]) begin
      ext_cnt_next = '0;
    end else if (!ext_rst) begin
      ext_cnt_next = ext_cnt_reg + 24'h1; // RL2
    end
    case (state_reg)
      SRSM_OFF: begin
        drive_next = 1'b1;
        cnt_next = '0;
        if (sync2_reg[P_PON]) begin
          state_next = SRSM_STARTUP;
        end
      end
      SRSM_STARTUP: begin
        cnt_next = cnt_reg + 24'h1;
        if (!sync2_reg[P_PON]) begin
          state_next = SRSM_OFF;
        end else if (cnt_reg >= STARTUP_CYC - 24'h1) begin
          state_next = SRSM_RESET; // RL13
          load_ctl = 1'b1; // RL6 RL15
          cold_next = 1'b1; // RL3
          cnt_next = '0;
        end
      end
      SRSM_RESET: begin
        drive_next = 1'b1; // RL1
        cnt_next = cnt_reg + 24'h1;
        if (uv_sel) begin
          cold_next = 1'b1; // RL3
          cnt_next = '0;
        end else if (warm_src) begin
          cnt_next = '0; // RL4
        end else if (cnt_reg >= plen - 24'h1) begin
          state_next = SRSM_RUN; // RL21
          drive_next = 1'b0;
          guard_next = C_SENSE_GUARD;
          stby_next = stby_reg;
        end
      end
      SRSM_OVERTEMP: begin
        drive_next = 1'b1; // RL9
        if (!sync2_reg[P_TREL]) begin
          state_next = SRSM_RESET; // RL10
          cold_next = 1'b1;
          cnt_next = '0;
          stby_next = 1'b1;
        end
      end
      SRSM_RUN: begin
        if (uv_sel || (sleep_mode && sleep_wake_in)) begin
          state_next = SRSM_RESET; // RL3 RL7 RL8
          cold_next = 1'b1;
          drive_next = 1'b1;
          cnt_next = '0;
        end else if (warm_src) begin
          state_next = SRSM_RESET; // RL4 RL7
          cold_next = 1'b0;
          drive_next = 1'b1;
          cnt_next = '0;
        end
      end
      default: state_next = SRSM_OFF;
    endcase
    // A pending Standby entry rides along until the pulse ends.
    if (state_reg == SRSM_RESET && state_next == SRSM_RESET) begin
      stby_next = stby_reg;
    end
    if (temp_mon && sync2_reg[P_TACT] && state_reg != SRSM_STARTUP) begin
      state_next = SRSM_OVERTEMP; // RL9
      drive_next = 1'b1;
    end
    if (sync2_reg[P_POFF]) begin
      state_next = SRSM_OFF; // RL12
      drive_next = 1'b1;
    end
  end

  // The inhibit variant keeps its level in Overtemp; the sensor variant
  // switches off so a hot part does not feed external loads.
  always_comb begin
    aux_next = 1'b0;
    case (auxcfg_reg) // RL18
      2'h1: aux_next = (state_reg == SRSM_RUN) && (op_mode_in == OPM_NORMAL);
      2'h2: aux_next = (state_reg == SRSM_RESET) || ((state_reg == SRSM_RUN)
        && (op_mode_in != OPM_SLEEP));
      2'h3: aux_next = (state_reg == SRSM_RESET) || (state_reg == SRSM_RUN);
      default: aux_next = 1'b0;
    endcase
    if (state_reg == SRSM_OVERTEMP) begin
      aux_next = HAS_SENSOR ? 1'b0 : aux_reg; // RL9
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= SRSM_OFF;
      cnt_reg <= '0;
      ext_cnt_reg <= '0;
      guard_reg <= '0;
      cold_reg <= 1'b1;
      stby_reg <= 1'b0;
      drive_reg <= 1'b1;
      aux_reg <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ext_cnt_reg <= ext_cnt_next;
      guard_reg <= guard_next;
      cold_reg <= cold_next;
      stby_reg <= stby_next;
      drive_reg <= drive_next;
      aux_reg <= aux_next;
    end
  end

  // Register file.
  always_comb begin
    if (!HAS_SENSOR) begin
      sstat = SST_OK; // RL19
    end else if (!aux_reg) begin
      sstat = SST_OFF;
    end else if (sync2_reg[P_SOV]) begin
      sstat = SST_OV;
    end else if (sync2_reg[P_SUV]) begin
      sstat = SST_UV;
    end else begin
      sstat = SST_OK;
    end
  end

  assign idx = paddr_in[9:2];
  assign hit = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0)
    && (idx == IDX_SUPPLY_CTRL || idx == IDX_SUPPLY_STAT
    || idx == IDX_STARTUP_CTRL || idx == IDX_CONFIG_CTRL
    || idx == IDX_EVENT_STAT || idx == IDX_EVENT_ENA);
  assign wr_acc = psel_in && penable_in && pwrite_in && hit;

  always_comb begin
    thr_next = thr_reg;
    auxcfg_next = auxcfg_reg;
    plen_next = plen_reg;
    auxsu_next = auxsu_reg;
    thrsu_next = thrsu_reg;
    warn_ena_next = warn_ena_reg;
    ev_next = ev_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (psel_in && !penable_in) begin
      err_next = !hit;
      rdata_next = '0;
      case (idx)
        IDX_SUPPLY_CTRL: begin
          rdata_next[F_AUXCFG_LSB +: 2] = auxcfg_reg;
          rdata_next[F_THR_LSB +: 2] = thr_reg;
        end
        IDX_SUPPLY_STAT: begin
          rdata_next[F_SSTAT_LSB +: 2] = sstat; // RL19
          rdata_next[F_BELOW] = sync2_reg[P_BELOW0]; // RL17
        end
        IDX_STARTUP_CTRL: begin
          rdata_next[F_PLEN_LSB +: 2] = plen_reg;
          rdata_next[F_AUXSU] = auxsu_reg;
        end
        IDX_CONFIG_CTRL: rdata_next[F_THRSU_LSB +: 2] = thrsu_reg;
        IDX_EVENT_STAT: rdata_next[2:0] = ev_reg;
        IDX_EVENT_ENA: begin
          rdata_next[F_EV_WARN] = warn_ena_reg;
          rdata_next[F_OVERTEMP_WARN_STATUS] = sync2_reg[P_TWARN]; // RL11
        end
        default: rdata_next = '0;
      endcase
      if (!hit) begin
        rdata_next = '0;
      end
    end
    if (wr_acc) begin
      case (idx)
        IDX_SUPPLY_CTRL: begin
          thr_next = pwdata_in[F_THR_LSB +: 2]; // RL14
          auxcfg_next = pwdata_in[F_AUXCFG_LSB +: 2]; // RL18
        end
        IDX_STARTUP_CTRL: begin
          plen_next = pwdata_in[F_PLEN_LSB +: 2]; // RL5
          auxsu_next = pwdata_in[F_AUXSU]; // RL6
        end
        IDX_CONFIG_CTRL: thrsu_next = pwdata_in[F_THRSU_LSB +: 2]; // RL20
        IDX_EVENT_STAT: ev_next = ev_reg & ~pwdata_in[2:0];
        IDX_EVENT_ENA: warn_ena_next = pwdata_in[F_EV_WARN];
        default: ev_next = ev_next;
      endcase
    end
    if (load_ctl) begin
      thr_next = thrsu_reg; // RL15
      auxcfg_next = auxsu_reg ? 2'h3 : 2'h0; // RL6
    end
    // Hardware sets win over a same-cycle software clear.
    if (warn_ena_reg && sync2_reg[P_BELOW0] && !prev_reg[P_BELOW0]) begin
      ev_next[F_EV_WARN] = 1'b1; // RL16
    end
    if (temp_mon && sync2_reg[P_TWARN] && !prev_reg[P_TWARN]) begin
      ev_next[F_EV_OTW] = 1'b1; // RL11
    end
    if (load_ctl) begin
      ev_next[F_EV_PO] = 1'b1; // RL13
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      thr_reg <= RST_THR;
      auxcfg_reg <= RST_AUXCFG;
      plen_reg <= RST_PLEN;
      auxsu_reg <= RST_AUXSU;
      thrsu_reg <= RST_THRSU;
      warn_ena_reg <= RST_WARN_ENA;
      ev_reg <= '0;
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (ce_in) begin
      thr_reg <= thr_next;
      auxcfg_reg <= auxcfg_next;
      plen_reg <= plen_next;
      auxsu_reg <= auxsu_next;
      thrsu_reg <= thrsu_next;
      warn_ena_reg <= warn_ena_next;
      ev_reg <= ev_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata_out = rdata_reg;
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && err_reg;
  assign bidir_reset_pin_out = 1'b0;
  assign bidir_reset_pin_oe_n_out = !drive_reg; // RL1
  assign reset_mode_out = (state_reg == SRSM_RESET);
  assign overtemp_mode_out = (state_reg == SRSM_OVERTEMP);
  assign off_mode_out = (state_reg == SRSM_OFF);
  assign enter_standby_out = stby_reg && (state_reg == SRSM_RUN); // RL10
  assign main_supply_en_out = (state_reg != SRSM_OVERTEMP); // RL9
  assign can_enable_out = (state_reg == SRSM_RUN); // RL9
  assign aux_output_en_out = aux_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  pin_low_reset_a: assert property ((state_reg == SRSM_RESET // RL1
    || state_reg == SRSM_OVERTEMP) |-> !bidir_reset_pin_oe_n_out)
    else $error("reset pin not driven in Reset or Overtemp");
  warm_length_a: assert property ((state_reg == SRSM_RESET && !cold_reg // RL4
    && state_next == SRSM_RUN) |-> cnt_reg == WARM_CYC - 24'h1)
    else $error("warm pulse length wrong");
  cold_length_a: assert property ((state_reg == SRSM_RESET && cold_reg // RL5
    && plen_reg == 2'h2 && state_next == SRSM_RUN)
    |-> cnt_reg == COLD2_CYC - 24'h1)
    else $error("cold pulse length wrong");
  uv_cold_a: assert property ((state_reg == SRSM_RUN && uv_sel // RL3
    && !sync2_reg[P_POFF] && !(temp_mon && sync2_reg[P_TACT]))
    |=> state_reg == SRSM_RESET && cold_reg)
    else $error("undervoltage did not start a cold reset");
  otp_enter_a: assert property ((state_reg == SRSM_RUN && !sleep_mode // RL9
    && sync2_reg[P_TACT] && !sync2_reg[P_POFF])
    |=> overtemp_mode_out && !main_supply_en_out)
    else $error("overtemperature not entered");
  otp_exit_a: assert property ($fell(overtemp_mode_out) // RL10
    && !off_mode_out |-> reset_mode_out && cold_reg && stby_reg)
    else $error("overtemperature exit not via cold Reset");
  off_enter_a: assert property (sync2_reg[P_POFF] |=> off_mode_out) // RL12
    else $error("power-off not entered");
  po_event_a: assert property ($rose(reset_mode_out) // RL13
    && $past(state_reg) == SRSM_STARTUP |-> ev_reg[F_EV_PO])
    else $error("power-on event not set");
  below_flag_a: assert property ((psel_in && !penable_in // RL17
    && paddr_in == {2'h0, IDX_SUPPLY_STAT, 2'h0})
    |=> rdata_reg[F_BELOW] == $past(sync2_reg[P_BELOW0]))
    else $error("below flag reads wrong");
  warn_event_a: assert property ((warn_ena_reg // RL16
    && $rose(sync2_reg[P_BELOW0])) |=> ev_reg[F_EV_WARN])
    else $error("undervoltage warning lost");
  aux_off_a: assert property ((auxcfg_reg == 2'h0 // RL18
    && state_reg != SRSM_OVERTEMP) |=> !aux_output_en_out)
    else $error("output on while configured off");

  warm_done_c: cover property (!cold_reg && $fell(reset_mode_out));
  cold_done_c: cover property (cold_reg && $fell(reset_mode_out));
  otp_seen_c: cover property ($rose(overtemp_mode_out));
  ext_reset_c: cover property (state_reg == SRSM_RUN && ext_rst);
endmodule : srsm_top
`default_nettype wire

/* verification/srsm_host_model.sv */
// Host microcontroller model sharing the open-drain reset line.
`timescale 1ns/1ps
`default_nettype none
module srsm_host_model #(
  parameter int MIN_CYC = 4
) (
  // Clock and request from the bench.
  input wire logic sys_clk_in,
  input wire logic pull_req_in,
  // Device side of the line.
  input wire logic dev_oe_n_in,
  output logic pin_out
);
  int hold_cnt = 0;
  // A short request is stretched so the host never pulls below the minimum.
  always @(posedge sys_clk_in) begin
    if (pull_req_in) begin
      hold_cnt <= MIN_CYC + 1;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  // Nobody pulling means the pull-up lifts the line.
  assign pin_out = (!dev_oe_n_in || hold_cnt > 0) ? 1'b0 : 1'b1;
endmodule : srsm_host_model
`default_nettype wire

/* verification/test_sbc_reset_supply_monitor.sv */
// Self-checking testbench of the reset and supply monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_sbc_reset_supply_monitor
  import srsm_pkg::*;
;
  localparam logic [23:0] LEN [4] = '{24'h28, 24'h1E, 24'h14, 24'h0A};
  localparam logic [23:0] WARM = 24'h0A;
  localparam int WSRC [5] = '{0, 1, 3, 5, 2};
  logic sys_clk, rst, psel, penable, pwrite, pull, pin, err, ce, pdrv;
  logic sb_seen = 1'b0;
  logic t_act, t_rel, t_warn, poff, pon, suv, sov, wdp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] below;
  logic [1:0] op;
  logic [5:0] ev;
  logic pready, pslverr, oe_n, rmode, otmode, offmode, stby, v1en, canen, auxen;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  srsm_top #(.COLD0_CYC(LEN[0]), .COLD1_CYC(LEN[1]), .COLD2_CYC(LEN[2]),
    .WARM_CYC(WARM), .STARTUP_CYC(24'h08), .RST_IN_MIN_CYC(24'h04),
    .HAS_SENSOR(1'b1)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .bidir_reset_pin_in(pin), .bidir_reset_pin_out(pdrv),
    .bidir_reset_pin_oe_n_out(oe_n), .main_supply_below_in(below),
    .temp_above_act_in(t_act), .temp_above_rel_in(t_rel),
    .temp_above_warn_in(t_warn), .bat_below_poff_in(poff),
    .bat_above_pon_in(pon), .sensor_uv_in(suv), .sensor_ov_in(sov),
    .op_mode_in(op), .wd_overflow_window_in(ev[0]),
    .wd_early_trigger_in(ev[1]), .wd_overflow_timeout_in(ev[2]),
    .watchdog_failure_pending_in(wdp), .wd_ctrl_write_in(ev[3]),
    .sleep_wake_in(ev[4]), .illegal_sleep_cmd_in(ev[5]),
    .reset_mode_out(rmode), .overtemp_mode_out(otmode),
    .off_mode_out(offmode), .enter_standby_out(stby),
    .main_supply_en_out(v1en), .can_enable_out(canen),
    .aux_output_en_out(auxen));

  srsm_host_model #(.MIN_CYC(4)) host (.sys_clk_in(sys_clk),
    .pull_req_in(pull), .dev_oe_n_in(oe_n), .pin_out(pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // The ceiling is several times the expected run length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (stby === 1'b1) sb_seen <= 1'b1;
    if (cyc == 6000) begin
      report_and_stop(1'b1);
    end
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : ba

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic fire(input int i);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev <= '0;
  endtask : fire

  // Waits for a reset pulse and checks its length against the expectation.
  task automatic wait_rst(input logic [23:0] e);
    int n;
    n = 0;
    while (rmode !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("pin drive", 2'h0, {oe_n, pdrv})
    n = 0;
    while (rmode === 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("pulse len", 1'b1, n + 1 >= e && n <= e + 8)
    `CHK("pin release", 1'b1, oe_n & pin)
  endtask : wait_rst

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // A timeout counts as one more mismatch.
  task automatic report_and_stop(input bit timed_out);
    $display("checks %0d mismatches %0d", checks_done,
      error_cnt + int'(timed_out));
    if (error_cnt == 0 && checks_done > 0 && !timed_out) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {psel, penable, pwrite, pull, t_act, t_rel, t_warn} = '0;
    {poff, pon, suv, sov, wdp} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    below = '0;
    op = OPM_NORMAL;
    ev = '0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK("off", 1'b1, offmode)
    pon <= 1'b1;
    wait_rst(LEN[0]);
    apb(1'b0, ba(IDX_EVENT_STAT), 32'h0);
    `CHK("po", 1'b1, q[F_EV_PO])
    apb(1'b0, ba(IDX_SUPPLY_CTRL), 32'h0);
    `CHK("supply ctrl", 32'h0, q)
    apb(1'b0, ba(IDX_STARTUP_CTRL), 32'h0);
    `CHK("startup ctrl", 32'h0, q)
    apb(1'b0, ba(IDX_CONFIG_CTRL), 32'h0);
    `CHK("config ctrl", 32'h0, q)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK("unmapped", 1'b1, err)
    done("power_on");
    for (int k = 0; k < 5; k++) begin
      wdp <= (WSRC[k] == 2);
      fire(WSRC[k]);
      wait_rst(WARM);
    end
    wdp <= 1'b0;
    fire(2);
    repeat (6) @(posedge sys_clk);
    `CHK("timeout alone", 1'b0, rmode)
    done("warm");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ba(IDX_STARTUP_CTRL), 32'(s) << F_PLEN_LSB);
      op <= OPM_SLEEP;
      fire(4);
      wait_rst(LEN[s]);
      op <= OPM_NORMAL;
    end
    pull <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pull <= 1'b0;
    wait_rst(WARM);
    done("cold_ext");
    apb(1'b1, ba(IDX_EVENT_ENA), 32'h1);
    apb(1'b1, ba(IDX_SUPPLY_CTRL), 32'h3);
    below <= 4'h7;
    repeat (8) @(posedge sys_clk);
    `CHK("above thr", 1'b0, rmode)
    apb(1'b0, ba(IDX_SUPPLY_STAT), 32'h0);
    `CHK("below flag", 1'b1, q[F_BELOW])
    apb(1'b0, ba(IDX_EVENT_STAT), 32'h0);
    `CHK("uv warn", 1'b1, q[F_EV_WARN])
    ce <= 1'b0;
    below <= 4'hF;
    repeat (6) @(posedge sys_clk);
    `CHK("frozen", 2'h0, {rmode, pready})
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    below <= 4'h0;
    wait_rst(LEN[3]);
    apb(1'b1, ba(IDX_EVENT_STAT), 32'h7);
    done("threshold");
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 2; m++) begin
        apb(1'b1, ba(IDX_SUPPLY_CTRL), 32'(c) << F_AUXCFG_LSB);
        op <= (m == 1) ? OPM_STANDBY : OPM_NORMAL;
        repeat (3) @(posedge sys_clk);
        `CHK("aux", (m == 1) ? c >= 2 : c != 0, auxen)
      end
    end
    op <= OPM_NORMAL;
    suv <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ba(IDX_SUPPLY_STAT), 32'h0);
    `CHK("sensor uv", SST_UV, q[2:1])
    suv <= 1'b0;
    sov <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ba(IDX_SUPPLY_STAT), 32'h0);
    `CHK("sensor ov", SST_OV, q[2:1])
    sov <= 1'b0;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ba(IDX_SUPPLY_STAT), 32'h0);
    `CHK("status ok", {SST_OK, 1'b0}, q[2:0])
    done("supplies");
    t_warn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ba(IDX_EVENT_ENA), 32'h0);
    `CHK("otw status", 1'b1, q[F_OVERTEMP_WARN_STATUS])
    apb(1'b0, ba(IDX_EVENT_STAT), 32'h0);
    `CHK("otw event", 1'b1, q[F_EV_OTW])
    {t_act, t_rel} <= 2'h3;
    repeat (5) @(posedge sys_clk);
    `CHK("overtemp", 5'h10, {otmode, oe_n, v1en, canen, auxen})
    {t_act, t_rel, t_warn} <= 3'h0;
    wait_rst(LEN[3]);
    repeat (2) @(posedge sys_clk);
    `CHK("standby", 1'b1, sb_seen)
    done("overtemp");
    apb(1'b1, ba(IDX_STARTUP_CTRL), 32'h8);
    apb(1'b1, ba(IDX_CONFIG_CTRL), 32'h20);
    poff <= 1'b1;
    pon <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK("power off", 1'b1, offmode)
    poff <= 1'b0;
    pon <= 1'b1;
    wait_rst(LEN[0]);
    apb(1'b0, ba(IDX_SUPPLY_CTRL), 32'h0);
    `CHK("startup load", 32'hE, q)
    apb(1'b0, ba(IDX_EVENT_STAT), 32'h0);
    `CHK("po again", 1'b1, q[F_EV_PO])
    done("power_cycle");
    report_and_stop(1'b0);
  end
endmodule : test_sbc_reset_supply_monitor
`default_nettype wire
